// >>> common/efs_regs.svh
// register offsets, field positions, reset values and tag codes of the ecg sample fifo
`ifndef EFS_REGS_SVH
`define EFS_REGS_SVH

`define EFS_REG_CTRL 8'h00
`define EFS_REG_THRESH 8'h04
`define EFS_REG_STATUS 8'h08

`define EFS_CTRL_CLEAR_BIT 0
`define EFS_CTRL_RESYNC_BIT 1
`define EFS_STAT_OVF_BIT 0
`define EFS_STAT_IRQ_BIT 1
`define EFS_STAT_COUNT_LSB 8
`define EFS_THRESH_RESET 5'h0f

`define EFS_SPI_ADDR_BURST 7'h20
`define EFS_SPI_ADDR_NORMAL 7'h21

`define EFS_DEPTH 6'h20
`define EFS_LAST_CMD_BIT 5'h07
`define EFS_LAST_DATA_BIT 5'h17

`define EFS_TAG_EMPTY 3'h6
`define EFS_TAG_OVERFLOW 3'h7
`define EFS_PACE_NONE 3'h7

`endif

// >>> common/efs_pkg.sv
// types shared by the ecg sample fifo
package efs_pkg;

  typedef enum logic [1:0]
  {
    EFS_PH_CMD = 2'b00,
    EFS_PH_DATA = 2'b01,
    EFS_PH_SKIP = 2'b10
  } efs_phase_type;

endpackage : efs_pkg

// >>> core/efs_pin_sync.sv
// three-flop synchroniser with agreement filter for link pins
`timescale 1ns/1ps
module efs_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // raw pins and filtered level
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_d;

  // first stage feeds only the second; a change counts once stages two and three agree
  always_comb
  begin
    level_d = (s2_q & s3_q) | (level_q & (s2_q ^ s3_q)) | (s2_q & ~s3_q & level_q);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_q <= RST_VAL;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

endmodule : efs_pin_sync

// >>> core/efs_sample_ram.sv
// sample storage array of the ecg fifo
`timescale 1ns/1ps
module efs_sample_ram (
  // clock
  input wire logic clk_sys,
  // write side
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [23:0] wr_data,
  // read side
  input wire logic [4:0] rd_addr,
  output logic [23:0] rd_data
);

  logic [23:0] mem [0:31];

  // data only, so no reset: pointers decide what is valid
  always_comb
  begin
    rd_data = mem[rd_addr];
  end

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

endmodule : efs_sample_ram

// >>> core/efs_ecg_fifo.sv
// ecg sample fifo with sample and pace tagging, read over a serial link
// Behaviour
// - voltage: 18-bit signed, left justified in word
// - status tag sits in bits 5..3
// - tag 000: valid sample, more follow
// - tag 001: fast recovery sample, time valid
// - tag 010: valid sample, last one held
// - tag 011: fast recovery, last one held
// - tag 110: read of empty fifo
// - tag 111: fifo has overflowed
// - overflow sets status flag
// - clear command empties fifo after overflow
// - resync restarts channel timing, empties fifo
// - pace tag sits in bits 2..0
// - pace tag 000..101 names pace group
// - pace tag 111 when no pace event
// - circular store, 32 words of 24 bits
// - consume on 32nd edge, then every 24
// - fill flag when unread reaches threshold
`timescale 1ns/1ps
`include "efs_regs.svh"
module efs_ecg_fifo (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // sample channel
  input wire logic smp_valid,
  input wire logic [17:0] smp_voltage,
  input wire logic smp_fast,
  input wire logic smp_pace_hit,
  input wire logic [2:0] smp_pace_group,
  // serial link
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_q,
  output logic spi_miso_oe_q,
  // status
  output logic ecg_fill_interrupt_q,
  output logic ecg_overflow_flag_q,
  output logic channel_resync_command_q
);

  // builds the word handed to the reader from a stored entry
  function automatic logic [23:0] efs_tag_word(
    input logic [23:0] stored,
    input logic [5:0] avail,
    input logic ovf
  );
    logic [2:0] tag;
    tag = {1'b0, (avail == 6'h01), stored[3]};
    if (ovf)
    begin
      tag = `EFS_TAG_OVERFLOW;
    end
    else if (avail == 6'h00)
    begin
      tag = `EFS_TAG_EMPTY;
    end
    efs_tag_word = {stored[23:6], tag, stored[2:0]};
  endfunction : efs_tag_word

  // link pins, filtered
  logic [2:0] pins;
  logic [2:0] pins_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;

  efs_pin_sync #(
    .W(3),
    .RST_VAL(3'h2)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin_in({spi_sclk, spi_cs_n, spi_mosi}),
    .level_q(pins)
  );

  always_comb
  begin
    sclk_rise = pins[2] & ~pins_prev_q[2];
    sclk_fall = ~pins[2] & pins_prev_q[2];
    cs_active = ~pins[1];
  end

  // fifo state
  logic [4:0] wr_ptr_q;
  logic [4:0] wr_ptr_d;
  logic [4:0] rd_ptr_q;
  logic [4:0] rd_ptr_d;
  logic [5:0] count_q;
  logic [5:0] count_d;
  logic ovf_d;
  logic irq_d;
  logic resync_d;
  logic [4:0] thr_q;
  logic [4:0] thr_d;
  logic [31:0] rdata_d;
  logic clr;
  logic do_wr;
  logic ovf_evt;
  logic consume;
  logic [4:0] rd_index;
  logic [23:0] ram_word;
  logic [23:0] new_word;

  // serial engine state
  efs_pkg::efs_phase_type phase_q;
  efs_pkg::efs_phase_type phase_d;
  logic [4:0] bit_cnt_q;
  logic [4:0] bit_cnt_d;
  logic [6:0] cmd_q;
  logic [6:0] cmd_d;
  logic burst_q;
  logic burst_d;
  logic word_empty_q;
  logic word_empty_d;
  logic [23:0] shift_q;
  logic [23:0] shift_d;
  logic miso_d;
  logic oe_d;

  always_comb
  begin
    new_word = {smp_voltage, 2'b00, smp_fast, `EFS_PACE_NONE};
    if (smp_pace_hit)
    begin
      new_word[2:0] = smp_pace_group;
    end
  end

  efs_sample_ram u_ram (
    .clk_sys(clk_sys),
    .wr_en(do_wr),
    .wr_addr(wr_ptr_q),
    .wr_data(new_word),
    .rd_addr(rd_index),
    .rd_data(ram_word)
  );

  // serial engine: next state
  always_comb
  begin
    phase_d = phase_q;
    bit_cnt_d = bit_cnt_q;
    cmd_d = cmd_q;
    burst_d = burst_q;
    word_empty_d = word_empty_q;
    shift_d = shift_q;
    miso_d = spi_miso_q;
    consume = 1'b0;
    rd_index = rd_ptr_q;
    oe_d = cs_active & (phase_q == efs_pkg::EFS_PH_DATA);
    if (!cs_active)
    begin
      phase_d = efs_pkg::EFS_PH_CMD;
      bit_cnt_d = 5'h00;
      miso_d = 1'b0;
    end
    else if (sclk_rise)
    begin
      case (phase_q)
        efs_pkg::EFS_PH_CMD:
        begin
          cmd_d = {cmd_q[5:0], pins[0]};
          bit_cnt_d = bit_cnt_q + 5'h01;
          if (bit_cnt_q == `EFS_LAST_CMD_BIT)
          begin
            bit_cnt_d = 5'h00;
            phase_d = efs_pkg::EFS_PH_SKIP;
            if (pins[0] && (cmd_q == `EFS_SPI_ADDR_BURST || cmd_q == `EFS_SPI_ADDR_NORMAL))
            begin
              phase_d = efs_pkg::EFS_PH_DATA;
              burst_d = (cmd_q == `EFS_SPI_ADDR_BURST);
              shift_d = efs_tag_word(ram_word, count_q, ecg_overflow_flag_q);
              word_empty_d = (count_q == 6'h00);
            end
          end
        end
        efs_pkg::EFS_PH_DATA:
        begin
          bit_cnt_d = bit_cnt_q + 5'h01;
          if (bit_cnt_q == `EFS_LAST_DATA_BIT)
          begin
            bit_cnt_d = 5'h00;
            consume = ~word_empty_q & ~clr;
            rd_index = rd_ptr_q + {4'h0, consume};
            if (burst_q)
            begin
              // the eof tag looks only at words already stored, a late write shows next read
              shift_d = efs_tag_word(ram_word, count_q - {5'h00, consume}, ecg_overflow_flag_q);
              word_empty_d = ((count_q - {5'h00, consume}) == 6'h00);
            end
            else
            begin
              phase_d = efs_pkg::EFS_PH_SKIP;
            end
          end
        end
        efs_pkg::EFS_PH_SKIP:
        begin
          bit_cnt_d = bit_cnt_q;
        end
        default:
        begin
          phase_d = efs_pkg::EFS_PH_CMD;
        end
      endcase
    end
    else if (sclk_fall && phase_q == efs_pkg::EFS_PH_DATA)
    begin
      miso_d = shift_q[23];
      shift_d = {shift_q[22:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      pins_prev_q <= 3'h2;
      phase_q <= efs_pkg::EFS_PH_CMD;
      bit_cnt_q <= 5'h00;
      cmd_q <= 7'h00;
      burst_q <= 1'b0;
      word_empty_q <= 1'b1;
      shift_q <= 24'h000000;
      spi_miso_q <= 1'b0;
      spi_miso_oe_q <= 1'b0;
    end
    else
    begin
      pins_prev_q <= pins;
      phase_q <= phase_d;
      bit_cnt_q <= bit_cnt_d;
      cmd_q <= cmd_d;
      burst_q <= burst_d;
      word_empty_q <= word_empty_d;
      shift_q <= shift_d;
      spi_miso_q <= miso_d;
      spi_miso_oe_q <= oe_d;
    end
  end

  // fifo pointers, flags and registers: next state
  always_comb
  begin
    clr = reg_wr && reg_addr == `EFS_REG_CTRL &&
      (reg_wdata[`EFS_CTRL_CLEAR_BIT] || reg_wdata[`EFS_CTRL_RESYNC_BIT]);
    resync_d = reg_wr && reg_addr == `EFS_REG_CTRL && reg_wdata[`EFS_CTRL_RESYNC_BIT];
    ovf_evt = smp_valid && count_q == `EFS_DEPTH && !consume;
    do_wr = smp_valid && !clr && (count_q != `EFS_DEPTH || consume);
    ovf_d = ecg_overflow_flag_q;
    thr_d = thr_q;
    if (reg_wr && reg_addr == `EFS_REG_THRESH)
    begin
      thr_d = reg_wdata[4:0];
    end
    if (clr)
    begin
      wr_ptr_d = 5'h00;
      rd_ptr_d = 5'h00;
      count_d = 6'h00;
      ovf_d = 1'b0;
    end
    else
    begin
      wr_ptr_d = wr_ptr_q + {4'h0, do_wr};
      rd_ptr_d = rd_ptr_q + {4'h0, consume};
      count_d = count_q + {5'h00, do_wr} - {5'h00, consume};
    end
    // overflow sets even in the cycle of a clear: an event is never lost
    if (ovf_evt)
    begin
      ovf_d = 1'b1;
    end
    // threshold holds n-1, so unread >= n reads as unread > field
    irq_d = (count_q > {1'b0, thr_q});
    rdata_d = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        `EFS_REG_THRESH:
        begin
          rdata_d = {27'h0, thr_q};
        end
        `EFS_REG_STATUS:
        begin
          rdata_d[`EFS_STAT_OVF_BIT] = ecg_overflow_flag_q;
          rdata_d[`EFS_STAT_IRQ_BIT] = ecg_fill_interrupt_q;
          rdata_d[`EFS_STAT_COUNT_LSB +: 6] = count_q;
        end
        default:
        begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      wr_ptr_q <= 5'h00;
      rd_ptr_q <= 5'h00;
      count_q <= 6'h00;
      thr_q <= `EFS_THRESH_RESET;
      ecg_overflow_flag_q <= 1'b0;
      ecg_fill_interrupt_q <= 1'b0;
      channel_resync_command_q <= 1'b0;
      reg_rdata_q <= 32'h00000000;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      thr_q <= thr_d;
      ecg_overflow_flag_q <= ovf_d;
      ecg_fill_interrupt_q <= irq_d;
      channel_resync_command_q <= resync_d;
      reg_rdata_q <= rdata_d;
    end
  end

endmodule : efs_ecg_fifo

// >>> verification/efs_monitor.sv
// port assertions for the ecg sample fifo
`timescale 1ns/1ps
`include "efs_regs.svh"
module efs_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // sample channel
  input wire logic smp_valid,
  // status
  input wire logic ecg_fill_interrupt_q,
  input wire logic ecg_overflow_flag_q,
  input wire logic channel_resync_command_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic ctl;
  assign ctl = reg_wr && reg_addr == `EFS_REG_CTRL;
  property p_ovf_hold;
    ecg_overflow_flag_q && !ctl |=> ecg_overflow_flag_q;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");
  property p_ovf_clr;
    ctl && reg_wdata[0] && !smp_valid |=> !ecg_overflow_flag_q;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("clear kept overflow");
  property p_clr_fill;
    ctl && reg_wdata[0] && !smp_valid ##1 !smp_valid |=> !ecg_fill_interrupt_q;
  endproperty
  a_clr_fill: assert property (p_clr_fill) else $error("clear left entries");
  property p_sync_pulse;
    ctl && reg_wdata[1] |=> channel_resync_command_q;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("no resync pulse");
  property p_sync_only;
    !(ctl && reg_wdata[1]) |=> !channel_resync_command_q;
  endproperty
  a_sync_only: assert property (p_sync_only) else $error("stray resync pulse");
  property p_sync_ovf;
    ctl && reg_wdata[1] && !smp_valid |=> !ecg_overflow_flag_q;
  endproperty
  a_sync_ovf: assert property (p_sync_ovf) else $error("resync kept overflow");
  property p_ovf_full;
    $rose(ecg_overflow_flag_q) |-> ecg_fill_interrupt_q;
  endproperty
  a_ovf_full: assert property (p_ovf_full) else $error("overflow below 32");
  property p_fill_rise;
    $rose(ecg_fill_interrupt_q) && !$past(reg_wr, 2) |-> $past(smp_valid, 2);
  endproperty
  a_fill_rise: assert property (p_fill_rise) else $error("fill rose unprompted");
  c_ovf: cover property ($rose(ecg_overflow_flag_q));
  c_sync: cover property (channel_resync_command_q);
  c_fill: cover property ($rose(ecg_fill_interrupt_q));
endmodule : efs_monitor

bind efs_ecg_fifo efs_monitor u_mon (.*);

// >>> verification/efs_spi_reader.sv
// serial reader model, mode 0, msb first
`timescale 1ns/1ps
module efs_spi_reader (
  // link pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  logic [23:0] w [4];
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // sclk idles low between frames; mosi toggles once unused
  task automatic xfer(input logic [6:0] a, input int n);
    logic [7:0] c;
    c = {a, 1'b1};
    spi_cs_n = 1'b0;
    #62.5;
    for (int i = 0; i < 8 + 24 * n; i++)
    begin
      spi_mosi = (i < 8) ? c[7 - i] : ~spi_mosi;
      #62.5 spi_sclk = 1'b1;
      if (i >= 8)
        w[(i - 8) / 24] = {w[(i - 8) / 24][22:0], spi_miso};
      #62.5 spi_sclk = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #250;
  endtask : xfer
endmodule : efs_spi_reader

// >>> verification/tb_top.sv
// self-checking bench for the ecg sample fifo
`timescale 1ns/1ps
`include "efs_regs.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic smp_valid = 1'b0;
  logic [17:0] smp_voltage = 18'h0;
  logic smp_fast = 1'b0;
  logic smp_pace_hit = 1'b0;
  logic [2:0] smp_pace_group = 3'h0;
  logic [31:0] reg_rdata_q;
  logic sclk, cs_n, mosi, miso_q, oe, miso_w, fill, ovf, sync;
  logic [23:0] q [$];
  logic o = 1'b0;
  int fails = 0;
  int checked = 0;
  int thr = 16;
  always #4 clk_sys = ~clk_sys;
  // released line shows the inverse of the last driven bit
  assign miso_w = oe ? miso_q : ~miso_q;
  efs_ecg_fifo u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .smp_valid(smp_valid),
    .smp_voltage(smp_voltage), .smp_fast(smp_fast), .smp_pace_hit(smp_pace_hit),
    .smp_pace_group(smp_pace_group), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso_q(miso_q), .spi_miso_oe_q(oe), .ecg_fill_interrupt_q(fill),
    .ecg_overflow_flag_q(ovf), .channel_resync_command_q(sync)
  );
  efs_spi_reader u_rd (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso_w));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [31:0] stat();
    return {18'h0, 6'(q.size()), 6'h0, q.size() >= thr, o};
  endfunction : stat
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg", e, reg_rdata_q);
  endtask : rd
  task automatic push(input int n);
    logic [17:0] v;
    logic f;
    logic h;
    logic [2:0] g;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      v = (i == 0) ? 18'h20000 : 18'($urandom);
      f = 1'($urandom);
      h = 1'($urandom);
      g = 3'($urandom_range(5));
      smp_valid <= 1'b1;
      smp_voltage <= v;
      smp_fast <= f;
      smp_pace_hit <= h;
      smp_pace_group <= g;
      if (q.size() < 32)
        q.push_back({v, 2'b00, f, h ? g : 3'h7});
      else
        o = 1'b1;
    end
    @(posedge clk_sys);
    smp_valid <= 1'b0;
  endtask : push
  // a read past what the model holds expects the empty tag 110 instead of a word
  task automatic sread(input logic [6:0] a, input int n);
    logic [23:0] e;
    u_rd.xfer(a, n);
    for (int i = 0; i < n; i++)
    begin
      if (q.size() == 0)
        chk("empty tag", 32'h6, 32'(u_rd.w[i][5:3]));
      else
      begin
        e = o ? q[0] | 24'h38 : q[0] | (q.size() == 1 ? 24'h10 : 24'h0);
        chk("word", 32'(e), 32'(u_rd.w[i]));
        void'(q.pop_front());
      end
    end
    rd(`EFS_REG_STATUS, stat());
    chk("flags", 32'({q.size() >= thr, o}), 32'({fill, ovf}));
    chk("oe", 32'h0, 32'(oe));
  endtask : sread
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial
  begin
    #500000;
    fails++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(73));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(`EFS_REG_THRESH, 32'h0f);
    rd(`EFS_REG_STATUS, 32'h0);
    rd(8'h0c, 32'h0);
    rd(`EFS_REG_CTRL, 32'h0);
    sread(`EFS_SPI_ADDR_NORMAL, 1);
    $display("test reset_empty done");
    for (int k = 0; k < 6; k++)
    begin
      thr = $urandom_range(1, 8);
      wr(`EFS_REG_THRESH, 32'(thr - 1));
      push($urandom_range(1, 4));
      rd(`EFS_REG_STATUS, stat());
      sread(k[0] ? `EFS_SPI_ADDR_BURST : `EFS_SPI_ADDR_NORMAL,
        k[0] ? (q.size() > 4 ? 4 : q.size()) : 1);
    end
    $display("test traffic done");
    thr = 32;
    wr(`EFS_REG_THRESH, 32'h1f);
    push(33 - q.size());
    rd(`EFS_REG_STATUS, stat());
    sread(`EFS_SPI_ADDR_NORMAL, 1);
    wr(`EFS_REG_CTRL, 32'h1);
    q.delete();
    o = 1'b0;
    rd(`EFS_REG_STATUS, stat());
    push(2);
    sread(`EFS_SPI_ADDR_BURST, 2);
    $display("test overflow done");
    push(3);
    u_rd.xfer(7'h22, 1);
    chk("idle line", 32'hffffff, 32'(u_rd.w[0]));
    rd(`EFS_REG_STATUS, stat());
    wr(`EFS_REG_CTRL, 32'h2);
    #1 chk("resync", 32'h1, 32'(sync));
    q.delete();
    rd(`EFS_REG_STATUS, stat());
    $display("test resync done");
    wrap_up();
  end
endmodule : tb_top
